// [hw/dhrs_pkg.sv]
package dhrs_pkg;
    // Clock rate in kHz (200 MHz)
    localparam int CLK_KHZ = 200000;
    // Filter thresholds and reset-cancel periods in their own units
    localparam int REJECT_US = 5;
    localparam int ACCEPT_US = 9;
    localparam int NVM_MS = 5;
    localparam int BLANK_MS = 120;
    // Derived cycle counts; the accept point rounds down so 9 us always resets
    localparam int REJECT_CYC = (REJECT_US * CLK_KHZ + 999) / 1000;
    localparam int ACCEPT_CYC = (ACCEPT_US * CLK_KHZ) / 1000;
    localparam int NVM_CYC = (NVM_MS * CLK_KHZ);
    localparam int BLANK_CYC = (BLANK_MS * CLK_KHZ);
    // Accepted pulse length, between the reject and accept points
    localparam int FILT_CYC = (REJECT_CYC + ACCEPT_CYC) / 2;
    localparam int CNT_W = 25;
    // Sequencer states
    typedef enum logic [2:0] {
        DHRS_RUN,
        DHRS_HELD,
        DHRS_BLANK,
        DHRS_LOAD,
        DHRS_WAIT
    } dhrs_state_t;
endpackage : dhrs_pkg

// [hw/dhrs_reset_seq.sv]
`timescale 1ns/100ps
// Function
// (R01) Host holds reset low 10 us minimum
// (R02) Reject under 5 us, accept over 9 us
// (R03) Glitch filter stays active during held reset
// (R04) Reload nonvolatile settings within 5 ms
// (R05) Reset-cancel 5 ms from sleep-in
// (R06) Reset-cancel 120 ms from sleep-out
// (R07) Display blanked throughout resetting period
// (R08) Sleep-in reset keeps blank, no sequence
// (R09) Registers return to defaults after reset
// (R10) Host waits 5 ms before commands
// (R11) Host waits 120 ms before wake command; ready_for_wake holds it off only after a sleep-out reset
// (R12) Synchronise pin, count pulse width on clock
module dhrs_reset_seq #(
    parameter int FILT_CYCLES = dhrs_pkg::FILT_CYC,
    parameter int NVM_CYCLES = dhrs_pkg::NVM_CYC,
    parameter int BLANK_CYCLES = dhrs_pkg::BLANK_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic hw_reset_n,
    input wire logic sleep_out,
    input wire logic load_done,
    output logic ctrl_reset,
    output logic display_blank,
    output logic blank_seq_active,
    output logic load_start,
    output logic load_busy,
    output logic ready_for_cmd,
    output logic ready_for_wake
);
    import dhrs_pkg::*;

    // Fixed cycles from pin release to ready_for_cmd besides filter and settle: two sync flops, filter confirm, load entry, run entry, output register
    localparam int PIPE_CYC = 6;
    // Last settle count, so commands open no later than the cancel bound after release
    localparam int CANCEL_LAST = NVM_CYCLES - FILT_CYCLES - PIPE_CYC;

    logic pin_meta;
    logic pin_sync;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic reset_held;
    logic [CNT_W-1:0] seq_cnt;
    logic [CNT_W-1:0] wake_cnt;
    logic from_sleep_out;
    logic blank_run;
    logic [CNT_W-1:0] blank_cnt;
    dhrs_state_t state;

    // Controller is held in reset in either holding state
    function automatic logic in_reset(input dhrs_state_t s);
        return (s == DHRS_HELD) || (s == DHRS_BLANK);
    endfunction : in_reset

    // Two-flop synchroniser for the pin; first stage feeds only the second
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= hw_reset_n; // R12
            pin_sync <= pin_meta;
        end
    end

    // Low-time counter; saturates so long pulses never wrap
    always_ff @(posedge clock) begin
        if (rst || pin_sync) begin
            low_cnt <= '0;
        end else if (low_cnt != {CNT_W{1'b1}}) begin
            low_cnt <= low_cnt + 1'b1; // R12
        end
    end

    // High-time counter so a short high spike cannot end a held reset
    always_ff @(posedge clock) begin
        if (rst || !pin_sync) begin
            high_cnt <= '0;
        end else if (high_cnt != {CNT_W{1'b1}}) begin
            high_cnt <= high_cnt + 1'b1; // R03
        end
    end

    // Held flag: set after filtered low time, cleared after filtered high time
    always_ff @(posedge clock) begin
        if (rst) begin
            reset_held <= 1'b0;
        end else if (low_cnt >= CNT_W'(FILT_CYCLES)) begin
            reset_held <= 1'b1; // R02
        end else if (high_cnt >= CNT_W'(FILT_CYCLES)) begin
            reset_held <= 1'b0; // R03
        end
    end

    // Blanking sequence timer; keeps running after an early release
    always_ff @(posedge clock) begin
        if (rst) begin
            blank_run <= 1'b0;
            blank_cnt <= '0;
        end else if (state == DHRS_RUN && reset_held && sleep_out) begin
            blank_run <= 1'b1; // R07
            blank_cnt <= '0;
        end else if (blank_run) begin
            blank_cnt <= blank_cnt + 1'b1;
            if (blank_cnt >= CNT_W'(BLANK_CYCLES - 1)) begin
                blank_run <= 1'b0; // R07
            end
        end
    end

    // Sequencer: held, load on release even mid-blank so the reload is never late
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= DHRS_RUN;
            seq_cnt <= '0;
            from_sleep_out <= 1'b0;
        end else begin
            case (state)
                DHRS_RUN: begin
                    seq_cnt <= '0;
                    if (reset_held) begin
                        from_sleep_out <= sleep_out;
                        state <= sleep_out ? DHRS_BLANK : DHRS_HELD; // R07 R08
                    end
                end
                DHRS_BLANK: begin
                    // Release starts the reload at once; blanking ends on its own timer
                    seq_cnt <= '0;
                    if (!reset_held) begin
                        state <= DHRS_LOAD; // R04
                    end else if (!blank_run) begin
                        state <= DHRS_HELD; // R07
                    end
                end
                DHRS_HELD: begin
                    seq_cnt <= '0;
                    if (!reset_held) begin
                        state <= DHRS_LOAD; // R04
                    end
                end
                DHRS_LOAD: begin
                    seq_cnt <= seq_cnt + 1'b1;
                    if (reset_held) begin
                        state <= DHRS_HELD;
                    end else if (load_done || seq_cnt >= CNT_W'(CANCEL_LAST - 1)) begin
                        state <= DHRS_WAIT; // R04
                    end
                end
                DHRS_WAIT: begin
                    seq_cnt <= seq_cnt + 1'b1;
                    if (reset_held) begin
                        state <= DHRS_HELD;
                    end else if (seq_cnt >= CNT_W'(CANCEL_LAST)) begin
                        state <= DHRS_RUN; // R05 R09
                    end
                end
                default: begin
                    state <= DHRS_RUN;
                end
            endcase
        end
    end

    // Wake guard counter from release; longer when reset came from sleep-out
    always_ff @(posedge clock) begin
        if (rst || in_reset(state)) begin
            wake_cnt <= '0;
        end else if (wake_cnt != {CNT_W{1'b1}}) begin
            wake_cnt <= wake_cnt + 1'b1; // R06
        end
    end

    // Registered outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reset <= 1'b1;
            display_blank <= 1'b1;
            blank_seq_active <= 1'b0;
            load_start <= 1'b0;
            load_busy <= 1'b0;
            ready_for_cmd <= 1'b0;
            ready_for_wake <= 1'b0;
        end else begin
            ctrl_reset <= in_reset(state); // R09
            display_blank <= (state != DHRS_RUN) || blank_run; // R07
            blank_seq_active <= blank_run; // R07
            load_start <= in_reset(state) && !reset_held; // R04
            load_busy <= (state == DHRS_LOAD); // R04
            ready_for_cmd <= (state == DHRS_RUN) && !reset_held; // R10
            ready_for_wake <= (state == DHRS_RUN) && !reset_held
                && (!from_sleep_out || wake_cnt >= CNT_W'(BLANK_CYCLES)); // R11
        end
    end

    // Short low pulses never reach the controller reset
    a_spike_reject: assert property (@(posedge clock) disable iff (rst) // R02
        $rose(reset_held) |-> $past(low_cnt) >= CNT_W'(FILT_CYCLES))
        else $error("reset accepted before filter time");
    a_held_glitch: assert property (@(posedge clock) disable iff (rst) // R03
        ($fell(reset_held) && !$past(rst)) |-> $past(high_cnt) >= CNT_W'(FILT_CYCLES))
        else $error("held reset dropped by short glitch");
    a_sleep_in_path: assert property (@(posedge clock) disable iff (rst) // R08
        (state == DHRS_RUN && reset_held && !sleep_out) |=> state == DHRS_HELD)
        else $error("sleep-in reset ran blanking sequence");
    a_sleep_in_clean: assert property (@(posedge clock) disable iff (rst) // R08
        (state == DHRS_RUN && reset_held && !sleep_out && !blank_run) |=> !blank_run)
        else $error("sleep-in reset started blanking timer");
    a_sleep_out_path: assert property (@(posedge clock) disable iff (rst) // R06
        (state == DHRS_RUN && reset_held && sleep_out) |=> state == DHRS_BLANK)
        else $error("sleep-out reset skipped blanking");
    a_blank_during: assert property (@(posedge clock) disable iff (rst) // R07
        (state == DHRS_HELD) |=> display_blank)
        else $error("display not blanked during reset");
    a_blank_run: assert property (@(posedge clock) disable iff (rst) // R07
        blank_run |=> blank_seq_active && display_blank)
        else $error("blanking sequence not shown");

    // Release seen in a holding state: load entry, then the busy flag
    sequence s_load_entry;
        state == DHRS_LOAD ##1 load_busy;
    endsequence

    a_load_begin: assert property (@(posedge clock) disable iff (rst) // R04
        (in_reset(state) && !reset_held) |=> s_load_entry)
        else $error("load did not start after release");
    a_reload_start: assert property (@(posedge clock) disable iff (rst) // R04
        ($fell(reset_held) && !$past(rst)) |=> load_start)
        else $error("reload not started on release");
    a_load_bound: assert property (@(posedge clock) disable iff (rst) // R05
        (state == DHRS_LOAD) |-> seq_cnt < CNT_W'(CANCEL_LAST))
        else $error("nonvolatile load exceeded bound");
    a_reset_hold: assert property (@(posedge clock) disable iff (rst) // R09
        (state == DHRS_BLANK) |=> ctrl_reset && !ready_for_cmd)
        else $error("controller not held in reset");
    // Commands only open at the end of the settle phase
    a_cmd_gate: assert property (@(posedge clock) disable iff (rst) // R10
        ($rose(ready_for_cmd) && !$past(rst, 2)) |-> $past(state, 2) == DHRS_WAIT)
        else $error("commands allowed during reset cancel");
endmodule : dhrs_reset_seq

// [bench/dhrs_host.sv]
`timescale 1ns/100ps
// Host pin driver and storage responder
module dhrs_host #(
    parameter int LOAD_LAT = 10
) (
    input wire logic clock,
    input wire logic load_start,
    output logic hw_reset_n,
    output logic load_done
);
    int lat = 0;
    initial begin
        hw_reset_n = 1'b1;
        load_done = 1'b0;
    end
    // Pin low for n cycles, optionally broken by a short high glitch
    task automatic pulse(input int n, input int glitch);
        @(negedge clock) hw_reset_n = 1'b0;
        repeat (n / 2) @(negedge clock);
        if (glitch > 0) begin
            hw_reset_n = 1'b1;
            repeat (glitch) @(negedge clock);
            hw_reset_n = 1'b0;
        end
        repeat (n - n / 2) @(negedge clock);
        hw_reset_n = 1'b1;
    endtask : pulse
    // Storage reports done a fixed while after the load begins
    always @(negedge clock) begin
        load_done <= (lat == 1);
        if (load_start) lat <= LOAD_LAT;
        else if (lat > 0) lat <= lat - 1;
    end
endmodule : dhrs_host

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
    localparam int FILT = 8;
    localparam int NVM = 50;
    localparam int BLANK = 100;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sleep_out = 1'b0;
    logic hw_reset_n, load_done, ctrl_reset, display_blank, blank_seq_active;
    logic load_start, load_busy, ready_for_cmd, ready_for_wake;
    int errors = 0;
    int tests_run = 0;
    int starts = 0;
    int s0;
    always #2.5 clock = ~clock;
    dhrs_reset_seq #(.FILT_CYCLES(FILT), .NVM_CYCLES(NVM), .BLANK_CYCLES(BLANK))
    i_dhrs_reset_seq (.clock(clock), .rst(rst), .hw_reset_n(hw_reset_n),
        .sleep_out(sleep_out), .load_done(load_done), .ctrl_reset(ctrl_reset),
        .display_blank(display_blank), .blank_seq_active(blank_seq_active),
        .load_start(load_start), .load_busy(load_busy),
        .ready_for_cmd(ready_for_cmd), .ready_for_wake(ready_for_wake));
    dhrs_host #(.LOAD_LAT(10)) i_dhrs_host (.clock(clock), .load_start(load_start),
        .hw_reset_n(hw_reset_n), .load_done(load_done));
    // Count reload starts on the falling edge, where the pulse has settled
    always @(negedge clock) if (load_start === 1'b1) starts++;
    task automatic check(input logic seen, input logic exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check
    // Bounded wait; long counts would hide a stuck sequencer
    task automatic wait_cmd(input int n);
        for (int i = 0; i < n && ready_for_cmd !== 1'b1; i++) @(negedge clock);
    endtask : wait_cmd
    task automatic wait_wake(input int n);
        for (int i = 0; i < n && ready_for_wake !== 1'b1; i++) @(negedge clock);
    endtask : wait_wake
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic t_spike;
        i_dhrs_host.pulse(4, 0);
        repeat (FILT + 6) @(negedge clock);
        check(ctrl_reset, 1'b0, "spike reset");
        check(ready_for_cmd, 1'b1, "spike ready");
    endtask : t_spike
    task automatic t_sleep_in;
        sleep_out = 1'b0;
        s0 = starts;
        i_dhrs_host.pulse(40, 3);
        check(starts == s0, 1'b1, "glitch released");
        check(display_blank, 1'b1, "no blank");
        check(blank_seq_active, 1'b0, "sequence in sleep");
        check(ready_for_cmd, 1'b0, "cmd during reset");
        // Commands must open within the cancel bound counted from release
        wait_cmd(NVM);
        check(ready_for_cmd, 1'b1, "cancel late");
        check(starts == s0 + 1, 1'b1, "no reload");
        check(ctrl_reset, 1'b0, "ctrl held");
        check(display_blank, 1'b0, "blank held");
        wait_wake(3);
        check(ready_for_wake, 1'b1, "wake late");
    endtask : t_sleep_in
    task automatic t_sleep_out;
        sleep_out = 1'b1;
        i_dhrs_host.pulse(20, 0);
        check(blank_seq_active, 1'b1, "no sequence");
        check(ready_for_wake, 1'b0, "wake early");
        // Reload starts on release, so commands open as in sleep-in
        wait_cmd(NVM);
        check(ready_for_cmd, 1'b1, "cancel late");
        check(display_blank, 1'b1, "blank cut short");
        repeat (BLANK - NVM - 1) @(negedge clock);
        check(ready_for_wake, 1'b0, "wake before cancel end");
        wait_wake(BLANK);
        check(ready_for_wake, 1'b1, "wake late");
        check(display_blank, 1'b0, "blank held");
        check(blank_seq_active, 1'b0, "sequence held");
        sleep_out = 1'b0;
    endtask : t_sleep_out
    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        repeat (3) @(negedge clock);
        check(ctrl_reset, 1'b0, "reset default");
        check(ready_for_cmd, 1'b1, "ready default");
        t_spike();
        t_sleep_in();
        t_sleep_out();
        close_out();
    end
    // Watchdog
    initial begin
        #25000;
        errors++;
        close_out();
    end
endmodule : tb
